// ==== hdl/sdsw_evt_if.sv ====
`timescale 1ns/1ns
interface sdsw_evt_if;
	sdsw_pkg::sdsw_op_mode_t op_mode;
	logic                    setpoint_ack;
	logic                    speed_zero;
	logic                    homing_attained;
	logic                    interpolation_running_flag;
	logic                    following_error;
	logic                    homing_error;
	logic                    mode_ack_bit;
	logic                    track_err_bit;

	modport top (
		output op_mode,
		output setpoint_ack,
		output speed_zero,
		output homing_attained,
		output interpolation_running_flag,
		output following_error,
		output homing_error,
		input  mode_ack_bit,
		input  track_err_bit
	);

	modport sel (
		input  op_mode,
		input  setpoint_ack,
		input  speed_zero,
		input  homing_attained,
		input  interpolation_running_flag,
		input  following_error,
		input  homing_error,
		output mode_ack_bit,
		output track_err_bit
	);
endinterface

// ==== hdl/sdsw_map.svh ====
`ifndef SDSW_MAP_SVH
`define SDSW_MAP_SVH

// object index at which the drive status word is read
`define SDSW_IDX_STATUS        16'h6041

// masks and values that identify each drive state
`define SDSW_MASK_WIDE         16'h004F
`define SDSW_MASK_NARROW       16'h006F
`define SDSW_VAL_NOT_PREPARED  16'h0000
`define SDSW_VAL_INHIBITED     16'h0040
`define SDSW_VAL_PREPARED      16'h0021
`define SDSW_VAL_SWITCHED_ON   16'h0023
`define SDSW_VAL_OP_ENABLED    16'h0027
`define SDSW_VAL_FAULT         16'h000F
`define SDSW_VAL_QUICK_STOP    16'h0007

// event flag bit positions
`define SDSW_BIT_POWER_ON      4
`define SDSW_BIT_WARNING       7
`define SDSW_BIT_REMOTE        9
`define SDSW_BIT_GOAL          10
`define SDSW_BIT_LIMIT         11
`define SDSW_BIT_MODE_ACK      12
`define SDSW_BIT_TRACK_ERR     13

// command word bits that take part in state transitions
`define SDSW_CMD_TRANS_MSB     3

// reset values
`define SDSW_RST_WORD          16'h0000
`define SDSW_RST_CMD           4'h0

`endif

// ==== hdl/sdsw_mode_sel.sv ====
`timescale 1ns/1ns
module sdsw_mode_sel (
	sdsw_evt_if.sel evt     // mode-dependent event selection
);
	import sdsw_pkg::*;

	always_comb begin
		evt.mode_ack_bit  = 1'b0;
		evt.track_err_bit = evt.following_error;
		unique case (evt.op_mode)
			SDSW_MODE_PROF_POS: begin
				evt.mode_ack_bit = evt.setpoint_ack;                // [RL12]
			end
			SDSW_MODE_PROF_VEL: begin
				evt.mode_ack_bit = evt.speed_zero;                  // [RL12]
			end
			SDSW_MODE_PROF_TRQ: begin
				evt.mode_ack_bit = 1'b0;
			end
			SDSW_MODE_HOMING: begin
				evt.mode_ack_bit  = evt.homing_attained;            // [RL12]
				evt.track_err_bit = evt.homing_error;               // [RL11]
			end
			SDSW_MODE_INTERP: begin
				evt.mode_ack_bit = evt.interpolation_running_flag;  // [RL12]
			end
			default: begin
				// unlisted mode codes carry no acknowledge
				evt.mode_ack_bit = 1'b0;
			end
		endcase
	end
endmodule

// ==== hdl/sdsw_pkg.sv ====
package sdsw_pkg;

	typedef enum logic [2:0] {
		SDSW_NOT_PREPARED = 3'b000,
		SDSW_INHIBITED    = 3'b001,
		SDSW_PREPARED     = 3'b010,
		SDSW_SWITCHED_ON  = 3'b011,
		SDSW_OP_ENABLED   = 3'b100,
		SDSW_FAULT_RESP   = 3'b101,
		SDSW_FAULT        = 3'b110,
		SDSW_QUICK_STOP   = 3'b111
	} sdsw_drive_state_t;

	typedef enum logic [2:0] {
		SDSW_MODE_PROF_POS = 3'b000,
		SDSW_MODE_PROF_VEL = 3'b001,
		SDSW_MODE_PROF_TRQ = 3'b010,
		SDSW_MODE_HOMING   = 3'b011,
		SDSW_MODE_INTERP   = 3'b100
	} sdsw_op_mode_t;

	typedef struct packed {
		logic [15:0] word;
		logic [15:0] rd_data;
		logic        rd_ack;
		logic        rd_err;
		logic        power_off;
		logic [3:0]  cmd_trans;
		logic        cmd_extra;
		logic        word_changed;
	} sdsw_state_t;

endpackage

// ==== hdl/sdsw_status_word.sv ====
// Behaviour
// [RL1] masked 004F: not prepared reads 0000, power-up inhibited reads 0040.
// [RL2] masked 006F: prepared 0021, switched on 0023, operation enabled 0027.
// [RL3] fault and fault response both read 000F under mask 004F.
// [RL4] quick stop reads 0007 under mask 006F, bit 5 clear.
// [RL5] master writes 0006 then polls until masked word equals 0021.
// [RL6] master may write 000F then wait for masked word 0027.
// [RL7] master masks the word and checks cleared bits as well as set ones.
// [RL8] only command bits 0 to 3 steer transitions; others assumed clear.
// [RL9] bits 0,1,2,3,5,6 form one joint state code.
// [RL10] each read shows present condition, never an older latched value.
// [RL11] flags: power on 4, warning 7, remote 9, goal 10, limit 11, error 13.
// [RL12] bit 12 carries the acknowledge chosen by the operating mode.
// [RL13] power-stage-off flag is set while output transistors are off.
// [RL14] master waits for the requested state before the next command.
// [RL15] bits 8, 14, 15 read zero; state code follows the state register.
`timescale 1ns/1ns
`include "sdsw_map.svh"
module sdsw_status_word (
	input  wire logic                       clk,                        // 25 MHz clock
	input  wire logic                       reset,                      // async reset, active high
	input  wire sdsw_pkg::sdsw_drive_state_t drive_state,               // internal drive state register
	input  wire sdsw_pkg::sdsw_op_mode_t    op_mode,                    // active operating mode
	input  wire logic                       power_stage_on,             // output transistors switched on
	input  wire logic                       warning,                    // warning condition
	input  wire logic                       remote,                     // power stage enabled via bus
	input  wire logic                       target_reached,             // goal attained
	input  wire logic                       internal_limit,             // limit clamp active
	input  wire logic                       setpoint_ack,               // set point acknowledge
	input  wire logic                       speed_zero,                 // zero velocity
	input  wire logic                       homing_attained,            // reference found
	input  wire logic                       interpolation_running_flag, // interpolation active
	input  wire logic                       following_error,            // tracking error
	input  wire logic                       homing_error,               // reference search error
	input  wire logic [15:0]                obj_index,                  // object index of a read
	input  wire logic                       rd_strobe,                  // read request, one cycle
	input  wire logic [15:0]                cmd_word,                   // command word written
	input  wire logic                       cmd_write,                  // command write, one cycle
	output logic      [15:0]                rd_data,                    // read answer data
	output logic                            rd_ack,                     // read answered, one cycle
	output logic                            rd_err,                     // unknown index, one cycle
	output logic      [15:0]                status_word,                // registered status word, one cycle behind the live word
	output logic                            power_off,                  // power stage off flag
	output logic      [3:0]                 cmd_trans,                  // transition bits of command
	output logic                            cmd_extra,                  // command had bits above 3 set
	output logic                            word_changed                // status word changed, one cycle
);
	import sdsw_pkg::*;

	sdsw_evt_if  evt ();
	sdsw_state_t st_q;
	sdsw_state_t st_d;
	logic [15:0] state_code;
	logic [15:0] word_now;

	assign evt.op_mode                    = op_mode;
	assign evt.setpoint_ack               = setpoint_ack;
	assign evt.speed_zero                 = speed_zero;
	assign evt.homing_attained            = homing_attained;
	assign evt.interpolation_running_flag = interpolation_running_flag;
	assign evt.following_error            = following_error;
	assign evt.homing_error               = homing_error;

	sdsw_mode_sel u_mode_sel (
		.evt (evt.sel)
	);

	// state code is a pure decode of the state register, so it can never lag it
	always_comb begin
		state_code = `SDSW_VAL_NOT_PREPARED;                    // [RL15]
		unique case (drive_state)
			SDSW_NOT_PREPARED: begin
				state_code = `SDSW_VAL_NOT_PREPARED;            // [RL1]
			end
			SDSW_INHIBITED: begin
				state_code = `SDSW_VAL_INHIBITED;               // [RL1]
			end
			SDSW_PREPARED: begin
				state_code = `SDSW_VAL_PREPARED;                // [RL2]
			end
			SDSW_SWITCHED_ON: begin
				state_code = `SDSW_VAL_SWITCHED_ON;             // [RL2]
			end
			SDSW_OP_ENABLED: begin
				state_code = `SDSW_VAL_OP_ENABLED;              // [RL2]
			end
			// the two fault states share one code by design
			SDSW_FAULT_RESP: begin
				state_code = `SDSW_VAL_FAULT;                   // [RL3]
			end
			SDSW_FAULT: begin
				state_code = `SDSW_VAL_FAULT;                   // [RL3]
			end
			SDSW_QUICK_STOP: begin
				state_code = `SDSW_VAL_QUICK_STOP;              // [RL4]
			end
		endcase
	end

	always_comb begin
		// only the joint state bits survive; flag bits are placed below
		word_now = state_code & (`SDSW_MASK_WIDE | `SDSW_MASK_NARROW);  // [RL9]
		word_now[`SDSW_BIT_POWER_ON]  = power_stage_on;         // [RL11]
		word_now[`SDSW_BIT_WARNING]   = warning;                // [RL11]
		word_now[`SDSW_BIT_REMOTE]    = remote;                 // [RL11]
		word_now[`SDSW_BIT_GOAL]      = target_reached;         // [RL11]
		word_now[`SDSW_BIT_LIMIT]     = internal_limit;         // [RL11]
		word_now[`SDSW_BIT_MODE_ACK]  = evt.mode_ack_bit;       // [RL12]
		word_now[`SDSW_BIT_TRACK_ERR] = evt.track_err_bit;      // [RL11]
	end

	always_comb begin
		st_d              = st_q;
		st_d.rd_ack       = 1'b0;
		st_d.rd_err       = 1'b0;
		st_d.word         = word_now;
		st_d.power_off    = ~power_stage_on;                    // [RL13]
		st_d.word_changed = (word_now != st_q.word);
		if (rd_strobe) begin
			// read data come from the live word, not from the registered copy
			if (obj_index == `SDSW_IDX_STATUS) begin
				st_d.rd_data = word_now;                        // [RL10]
				st_d.rd_ack  = 1'b1;
			end else begin
				st_d.rd_data = `SDSW_RST_WORD;
				st_d.rd_err  = 1'b1;
			end
		end
		if (cmd_write) begin
			st_d.cmd_trans = cmd_word[`SDSW_CMD_TRANS_MSB:0];   // [RL8]
			st_d.cmd_extra = |cmd_word[15:`SDSW_CMD_TRANS_MSB+1];  // [RL8]
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q.word         <= `SDSW_RST_WORD;
			st_q.rd_data      <= `SDSW_RST_WORD;
			st_q.rd_ack       <= 1'b0;
			st_q.rd_err       <= 1'b0;
			st_q.power_off    <= 1'b1;
			st_q.cmd_trans    <= `SDSW_RST_CMD;
			st_q.cmd_extra    <= 1'b0;
			st_q.word_changed <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rd_data      = st_q.rd_data;
	assign rd_ack       = st_q.rd_ack;
	assign rd_err       = st_q.rd_err;
	assign status_word  = st_q.word;
	assign power_off    = st_q.power_off;
	assign cmd_trans    = st_q.cmd_trans;
	assign cmd_extra    = st_q.cmd_extra;
	assign word_changed = st_q.word_changed;
endmodule

// ==== verification/sdsw_master_model.sv ====
`timescale 1ns/1ns
`include "sdsw_map.svh"
module sdsw_master_model (
	input	wire logic		clk,		// dut clock
	output	logic [15:0]		obj_index,	// read index
	output	logic			rd_strobe,	// read request
	output	logic [15:0]		cmd_word,	// command word
	output	logic			cmd_write,	// command strobe
	input	wire logic [15:0]	rd_data,	// read data
	input	wire logic		rd_ack,		// good read
	input	wire logic		rd_err		// bad read
);
	initial begin
		obj_index = 16'h0000;
		rd_strobe = 1'b0;
		cmd_word = 16'h0000;
		cmd_write = 1'b0;
	end
	task automatic rd(input logic [15:0] idx, output logic [15:0] d, output logic e);
		int n;
		@(posedge clk);
		obj_index <= idx;
		rd_strobe <= 1'b1;
		@(posedge clk);
		// one-cycle strobe: holding it longer would start a second read
		rd_strobe <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!rd_ack && !rd_err && n < 4);
		d = rd_data;
		e = rd_err | ~rd_ack;
		obj_index <= ~idx;	// a released index must not look like a held one
	endtask
	task automatic wr(input logic [15:0] w);
		@(posedge clk);
		cmd_word <= w;
		cmd_write <= 1'b1;
		@(posedge clk);
		cmd_write <= 1'b0;
		cmd_word <= ~w;
	endtask
	// no second command until the asked state shows; bounded so a stuck drive cannot hang
	task automatic step(input logic [15:0] w, m, v, output bit ok);
		logic [15:0] d;
		logic e;
		wr(w);
		ok = 0;
		repeat (50) if (!ok) begin
			rd(`SDSW_IDX_STATUS, d, e);
			ok = !e && (d & m) === v;
		end
	endtask
endmodule

// ==== verification/sdsw_status_word_sva.sv ====
`timescale 1ns/1ns
`include "sdsw_map.svh"
module sdsw_status_word_sva
	import sdsw_pkg::*;
(
	input	wire logic				clk,		// clock
	input	wire logic				reset,		// async reset
	input	wire sdsw_pkg::sdsw_drive_state_t	drive_state,	// drive state
	input	wire logic				power_stage_on,	// power stage on
	input	wire logic				warning,	// warning
	input	wire logic [15:0]			obj_index,	// read index
	input	wire logic				rd_strobe,	// read request
	input	wire logic [15:0]			cmd_word,	// command word
	input	wire logic				cmd_write,	// command strobe
	input	wire logic [15:0]			rd_data,	// read data
	input	wire logic				rd_ack,		// good read
	input	wire logic				rd_err,		// bad read
	input	wire logic [15:0]			status_word,	// registered word
	input	wire logic				power_off,	// power off flag
	input	wire logic [3:0]			cmd_trans,	// transition bits
	input	wire logic				cmd_extra,	// extra bits seen
	input	wire logic				word_changed	// change pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_read_ack: assert property (rd_strobe && obj_index == `SDSW_IDX_STATUS |=> rd_ack && !rd_err)
		else $error("status read not acknowledged");
	a_read_live: assert property (rd_strobe && obj_index == `SDSW_IDX_STATUS |=> rd_data == status_word)
		else $error("read data differs from present word");
	a_spare_zero: assert property ((status_word & 16'hC100) == 16'h0000)
		else $error("spare status bits not zero");
	a_flag_bits: assert property (1'b1 |=> status_word[4] == $past(power_stage_on)
		&& power_off == !$past(power_stage_on) && status_word[7] == $past(warning))
		else $error("power or warning flag wrong");
	a_enabled_code: assert property (drive_state == SDSW_OP_ENABLED
		|=> (status_word & `SDSW_MASK_NARROW) == `SDSW_VAL_OP_ENABLED)
		else $error("enabled state code wrong");
	a_fault_code: assert property (drive_state inside {SDSW_FAULT, SDSW_FAULT_RESP}
		|=> (status_word & `SDSW_MASK_WIDE) == `SDSW_VAL_FAULT)
		else $error("fault state code wrong");
	a_quick_code: assert property (drive_state == SDSW_QUICK_STOP
		|=> (status_word & `SDSW_MASK_NARROW) == `SDSW_VAL_QUICK_STOP)
		else $error("quick stop code wrong");
	a_cmd_bits: assert property (cmd_write |=> ($past(cmd_word) & 16'h000F) == {12'h000, cmd_trans}
		&& cmd_extra == (($past(cmd_word) & 16'hFFF0) != 16'h0000))
		else $error("command bits not captured");
	a_bad_read: assert property (rd_strobe && obj_index != `SDSW_IDX_STATUS |=> rd_err && !rd_ack && rd_data == 16'h0000)
		else $error("unknown index not refused");
	a_word_change: assert property (word_changed == (status_word != $past(status_word)))
		else $error("change pulse wrong");
endmodule

// ==== verification/servo_drive_status_word_tb_top.sv ====
`timescale 1ns/1ns
`include "sdsw_map.svh"
bind sdsw_status_word sdsw_status_word_sva u_sva (.clk, .reset, .drive_state, .power_stage_on, .warning, .obj_index,
	.rd_strobe, .cmd_word, .cmd_write, .rd_data, .rd_ack, .rd_err, .status_word, .power_off, .cmd_trans, .cmd_extra,
	.word_changed);
module servo_drive_status_word_tb_top;
	import sdsw_pkg::*;
	logic			clk = 0, reset = 1, follow = 0;
	logic [10:0]		ev = '0;
	sdsw_drive_state_t	drive_state = SDSW_NOT_PREPARED;
	sdsw_op_mode_t		op_mode = SDSW_MODE_PROF_POS;
	logic [15:0]		obj_index, cmd_word, rd_data, status_word;
	logic [3:0]		cmd_trans;
	logic			rd_strobe, cmd_write, rd_ack, rd_err, power_off, cmd_extra, word_changed;
	int			miscompares = 0, total_checks = 0;
	always #20 clk = ~clk;
	sdsw_status_word u_dut (.clk, .reset, .drive_state, .op_mode, .power_stage_on(ev[0]), .warning(ev[1]),
		.remote(ev[2]), .target_reached(ev[3]), .internal_limit(ev[4]), .setpoint_ack(ev[5]), .speed_zero(ev[6]),
		.homing_attained(ev[7]), .interpolation_running_flag(ev[8]), .following_error(ev[9]),
		.homing_error(ev[10]), .obj_index, .rd_strobe, .cmd_word, .cmd_write, .rd_data, .rd_ack, .rd_err,
		.status_word, .power_off, .cmd_trans, .cmd_extra, .word_changed);
	sdsw_master_model u_master (.clk, .obj_index, .rd_strobe, .cmd_word, .cmd_write, .rd_data, .rd_ack, .rd_err);
	// stands in for the drive state machine, one state per edge
	always @(posedge clk) if (follow) begin
		if (drive_state == SDSW_INHIBITED && cmd_trans === 4'h6) drive_state <= SDSW_PREPARED;
		else if (drive_state == SDSW_PREPARED && cmd_trans === 4'hF) drive_state <= SDSW_SWITCHED_ON;
		else if (drive_state == SDSW_SWITCHED_ON) drive_state <= SDSW_OP_ENABLED;
	end
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic rd(output logic [15:0] d);
		logic e;
		u_master.rd(`SDSW_IDX_STATUS, d, e);
		check("read refused", 16'(e), 16'h0000);
	endtask
	task automatic t_states();
		logic [15:0] m [8] = '{`SDSW_MASK_WIDE, `SDSW_MASK_WIDE, `SDSW_MASK_NARROW, `SDSW_MASK_NARROW,
			`SDSW_MASK_NARROW, `SDSW_MASK_WIDE, `SDSW_MASK_WIDE, `SDSW_MASK_NARROW};
		logic [15:0] v [8] = '{`SDSW_VAL_NOT_PREPARED, `SDSW_VAL_INHIBITED, `SDSW_VAL_PREPARED,
			`SDSW_VAL_SWITCHED_ON, `SDSW_VAL_OP_ENABLED, `SDSW_VAL_FAULT, `SDSW_VAL_FAULT, `SDSW_VAL_QUICK_STOP};
		logic [15:0] d;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			drive_state <= sdsw_drive_state_t'(i);
			ev <= 11'h7FF;
			rd(d);
			check("state code", d & m[i], v[i]);
		end
	endtask
	task automatic t_flags();
		int pos [5] = '{4, 7, 9, 10, 11};
		logic [15:0] d;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			ev <= 11'h001 << i;
			rd(d);
			check("flag bits", d & 16'hFF90, 16'h0001 << pos[i]);
			check("power off", 16'(power_off), 16'(i != 0));
		end
	endtask
	task automatic t_modes();
		sdsw_op_mode_t md [6] = '{SDSW_MODE_PROF_POS, SDSW_MODE_PROF_VEL, SDSW_MODE_HOMING, SDSW_MODE_INTERP,
			SDSW_MODE_PROF_TRQ, sdsw_op_mode_t'(3'h5)};
		int src [6] = '{5, 6, 7, 8, 5, 5};
		logic [15:0] d;
		for (int i = 0; i < 6; i++) for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			op_mode <= md[i];
			ev <= k ? (11'h1E0 & ~(11'h001 << src[i])) | 11'h200 : (11'h001 << src[i]) | (i == 2 ? 11'h400 : 11'h000);
			rd(d);
			check("mode ack", 16'(d[12]), 16'(k == 0 && i < 4));
			check("error flag", 16'(d[13]), 16'(k ? i != 2 : i == 2));
		end
	endtask
	task automatic t_bad_read();
		logic [15:0] d;
		logic e;
		u_master.rd(16'h6040, d, e);
		check("bad index refused", 16'(e), 16'h0001);
		check("bad index data", d, 16'h0000);
	endtask
	task automatic t_reset();
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		check("reset word", status_word, `SDSW_RST_WORD);
		check("reset data", rd_data, `SDSW_RST_WORD);
		check("reset command", 16'({cmd_extra, cmd_trans, rd_ack, rd_err, word_changed}), 16'h0000);
		check("reset power off", 16'(power_off), 16'h0001);
		reset <= 1'b0;
	endtask
	task automatic t_steps();
		bit ok;
		@(posedge clk);
		drive_state <= SDSW_INHIBITED;
		u_master.wr(16'h00F0);
		@(posedge clk);
		check("extra command", 16'({cmd_extra, cmd_trans}), 16'h0010);
		follow <= 1'b1;
		u_master.step(16'h0006, `SDSW_MASK_NARROW, `SDSW_VAL_PREPARED, ok);
		check("to prepared", 16'(ok), 16'h0001);
		check("plain command", 16'({cmd_extra, cmd_trans}), 16'h0006);
		u_master.step(16'h000F, `SDSW_MASK_NARROW, `SDSW_VAL_OP_ENABLED, ok);
		check("to enabled", 16'(ok), 16'h0001);
		follow <= 1'b0;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		check("reset power off", 16'(power_off), 16'h0001);
		reset <= 1'b0;
		t_states();
		t_flags();
		t_modes();
		t_bad_read();
		t_steps();
		t_reset();
		conclude();
	end
endmodule
